// file: src/pcmsig_codec.v
// What this block does
// [R1] shift eight bits in while receive sync high
// [R2] falling receive sync ends the input word
// [R3] received bits share sign, chord, step meaning
// [R4] signalling eighth bit decodes as half step; code applies it only while receive is routed to B
// [R5] controller never holds either sync high
// [R6] transmit sync low one master clock first
// [R7] receive sync low seventeen master clocks first
// [R8] selected signal value goes into LSB
// [R9] transmit select rise picks A, fall B
// [R10] receive route rise to A, fall B
// [R11] selects change only at frames six, twelve; code takes a select edge in any frame
// [R12] offset cycle precedes every conversion
// [R13] sign bit stable for zero input
// [R14] frame sync repeats every 125 microseconds
// [R15] frame sync about eight bit clocks wide
// [R16] decoded sample about 7 us after sync
// [R17] output driven during sync, floats after
// [R18] sync drops before ninth edge; then decode
// [R19] word is sign, three chord, four step
// [R20] conversion clock independent of link clocks
// [R21] words go most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "pcmsig_map.vh"
module pcmsig_codec (
  input  wire                        ref_clk,
  input  wire                        resetn,
  input  wire                        tx_frame_sync,
  input  wire                        tx_bit_clock,
  input  wire                        rx_frame_sync,
  input  wire                        rx_bit_clock,
  input  wire                        rx_data,
  output reg                         tx_data_out,
  output reg                         tx_data_oe,
  input  wire                        tx_signal_select,
  input  wire                        rx_signal_route,
  input  wire                        signal_in_a,
  input  wire                        signal_in_b,
  output reg                         signal_out_a,
  output reg                         signal_out_b,
  input  wire [`PCMSIG_WORD_W-1:0]   enc_code,
  input  wire                        enc_done,
  output reg                         enc_start,
  output reg                         enc_offset_null,
  output reg  [`PCMSIG_WORD_W-1:0]   dac_word,
  output reg  [`PCMSIG_LIN_W-1:0]    dac_level,
  output reg                         dac_sign,
  output reg                         dac_update
);
  localparam integer DAC_DLY =
    `PCMSIG_DAC_DLY_NS / `PCMSIG_CLK_NS;
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_NULL = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // ==========================================================
  // input synchronisers: link pins are foreign to ref_clk
  // ==========================================================
  reg [1:0] txs_m, txc_m, rxs_m, rxc_m, rxd_m, sel_m, rte_m;
  reg       txs_q, txc_q, rxs_q, rxc_q, sel_q, rte_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txs_m <= 2'h0; txc_m <= 2'h0; rxs_m <= 2'h0; rxc_m <= 2'h0;
      rxd_m <= 2'h0; sel_m <= 2'h0; rte_m <= 2'h0;
      txs_q <= 1'b0; txc_q <= 1'b0; rxs_q <= 1'b0; rxc_q <= 1'b0;
      sel_q <= 1'b0; rte_q <= 1'b0;
    end else begin
      txs_m <= {txs_m[0], tx_frame_sync};
      txc_m <= {txc_m[0], tx_bit_clock};
      rxs_m <= {rxs_m[0], rx_frame_sync};
      rxc_m <= {rxc_m[0], rx_bit_clock};
      rxd_m <= {rxd_m[0], rx_data};
      sel_m <= {sel_m[0], tx_signal_select};
      rte_m <= {rte_m[0], rx_signal_route};
      txs_q <= txs_m[1];
      txc_q <= txc_m[1];
      rxs_q <= rxs_m[1];
      rxc_q <= rxc_m[1];
      sel_q <= sel_m[1];
      rte_q <= rte_m[1];
    end
  end
  wire txs_rise = txs_m[1] & ~txs_q;
  wire txs_fall = ~txs_m[1] & txs_q;
  wire txc_rise = txc_m[1] & ~txc_q;
  wire rxs_fall = ~rxs_m[1] & rxs_q;
  wire rxc_rise = rxc_m[1] & ~rxc_q;

  // ==========================================================
  // signalling select latches (edge sensitive, not level)
  // ==========================================================
  reg use_b_tx;
  reg route_b_rx;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      use_b_tx   <= 1'b0;
      route_b_rx <= 1'b0;
    end else begin
      if (sel_m[1] & ~sel_q)
        use_b_tx <= 1'b0;                             // [R9]
      else if (~sel_m[1] & sel_q)
        use_b_tx <= 1'b1;                             // [R9]
      if (rte_m[1] & ~rte_q)
        route_b_rx <= 1'b0;                           // [R10]
      else if (~rte_m[1] & rte_q)
        route_b_rx <= 1'b1;                           // [R10]
    end
  end

  // ==========================================================
  // u-law expansion, sign-magnitude with inverted chord/step
  // ==========================================================
  function [`PCMSIG_LIN_W-1:0] pcmsig_expand;
    input [`PCMSIG_WORD_W-1:0] w;
    input                      half_lsb;
    reg   [2:0]                chord;
    reg   [3:0]                step;
    reg   [`PCMSIG_LIN_W-1:0]  mag;
    begin
      chord = ~w[`PCMSIG_CHORD_HI:`PCMSIG_CHORD_LO];  // [R3] [R19]
      step  = ~w[`PCMSIG_STEP_HI:`PCMSIG_STEP_LO];
      if (half_lsb)
        step[0] = 1'b0;
      // mag in half-step units: ((2*step+33) << chord) - 33
      // chord 0 step 0 decodes to zero, each step is two units there
      mag = ((({10'h000, step} << 1) + `PCMSIG_BIAS)
             << chord) - `PCMSIG_BIAS;
      if (half_lsb)
        mag = mag + (`PCMSIG_HALF_STEP << chord);     // [R4]
      pcmsig_expand = mag;
    end
  endfunction

  // ==========================================================
  // receive path: shift while sync high, latch on its fall, decode 280 clocks later
  // ==========================================================
  reg [`PCMSIG_WORD_W-1:0] rx_shift;
  reg [`PCMSIG_CNT_W-1:0]  rx_cnt;
  reg                      rx_pend;
  reg [`PCMSIG_WORD_W-1:0] rx_word;
  reg [15:0]               dac_cnt;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_shift     <= `PCMSIG_ZERO_CODE;
      rx_cnt       <= `PCMSIG_CNT_ZERO;
      rx_pend      <= 1'b0;
      rx_word      <= `PCMSIG_ZERO_CODE;
      dac_cnt      <= 16'h0000;
      dac_word     <= `PCMSIG_ZERO_CODE;
      dac_level    <= `PCMSIG_LIN_ZERO;
      dac_sign     <= 1'b0;
      dac_update   <= 1'b0;
      signal_out_a <= 1'b0;
      signal_out_b <= 1'b0;
    end else begin
      dac_update <= 1'b0;
      if (rxs_m[1] && rxc_rise && rx_cnt != `PCMSIG_BITS) begin
        rx_shift <= {rx_shift[`PCMSIG_WORD_W-2:0], rxd_m[1]}; // [R1] [R21]
        rx_cnt   <= rx_cnt + `PCMSIG_CNT_ONE;
      end
      if (rxs_fall) begin                              // [R2] [R18]
        rx_cnt  <= `PCMSIG_CNT_ZERO;
        rx_word <= rx_shift;
        rx_pend <= 1'b1;
        dac_cnt <= DAC_DLY[15:0];
        if (route_b_rx)
          signal_out_b <= rx_shift[`PCMSIG_SIG_BIT];   // [R10]
        else
          signal_out_a <= rx_shift[`PCMSIG_SIG_BIT];   // [R10]
      end else if (rx_pend) begin
        if (dac_cnt == 16'h0001) begin                 // [R16]
          rx_pend    <= 1'b0;
          dac_word   <= rx_word;
          dac_sign   <= rx_word[`PCMSIG_SIGN_BIT];
          // frames decoded while routed to B use the half-step weight
          dac_level  <= pcmsig_expand(rx_word, route_b_rx); // [R4]
          dac_update <= 1'b1;
        end
        dac_cnt <= dac_cnt - 16'h0001;
      end
    end
  end

  // ==========================================================
  // encoder sequencing: offset null then conversion
  // ==========================================================
  reg [1:0]               enc_st;
  reg [`PCMSIG_TMR_W-1:0] ofs_cnt;
  wire                    f_ready;
  reg                     f_valid;
  reg [`PCMSIG_WORD_W-1:0] f_data;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enc_st          <= ST_IDLE;
      ofs_cnt         <= `PCMSIG_TMR_ZERO;
      enc_start       <= 1'b0;
      enc_offset_null <= 1'b0;
      f_valid         <= 1'b0;
      f_data          <= `PCMSIG_ZERO_CODE;
    end else begin
      enc_start <= 1'b0;
      if (f_valid && f_ready)
        f_valid <= 1'b0;
      case (enc_st)
        ST_IDLE: begin
          // conversion pacing independent of the bit clock
          if (txs_rise && !f_valid) begin              // [R20]
            enc_st          <= ST_NULL;
            enc_offset_null <= 1'b1;                   // [R12]
            ofs_cnt         <= `PCMSIG_OFS_CYC;
          end
        end
        ST_NULL: begin
          if (ofs_cnt == `PCMSIG_TMR_ONE) begin
            enc_offset_null <= 1'b0;
            enc_start       <= 1'b1;
            enc_st          <= ST_CONV;
          end
          ofs_cnt <= ofs_cnt - `PCMSIG_TMR_ONE;
        end
        ST_CONV: begin
          if (enc_done) begin
            // sign passes through untouched by offset null
            f_data  <= {enc_code[`PCMSIG_SIGN_BIT:`PCMSIG_STEP_LO+1],
                        use_b_tx ? signal_in_b : signal_in_a}; // [R8] [R13]
            f_valid <= 1'b1;
            enc_st  <= ST_IDLE;
          end
        end
        default: enc_st <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // transmit: fifo then shifter, MSB first while sync high
  // ==========================================================
  wire [`PCMSIG_WORD_W-1:0] q_data;
  wire                      q_valid;
  reg                       q_take;
  pcmsig_fifo #(
    .WIDTH (`PCMSIG_WORD_W),
    .DEPTH (`PCMSIG_FIFO_DEPTH),
    .AW    (`PCMSIG_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_data   (f_data),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_take)
  );

  reg [`PCMSIG_WORD_W-1:0] tx_shift;
  always @* begin
    q_take = txs_rise & q_valid;
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_shift    <= `PCMSIG_ZERO_CODE;
      tx_data_out <= 1'b0;
      tx_data_oe  <= 1'b0;
    end else begin
      if (txs_rise) begin
        tx_data_oe  <= 1'b1;                            // [R17]
        tx_shift    <= q_valid ? q_data : `PCMSIG_ZERO_CODE;
        tx_data_out <= q_valid ? q_data[`PCMSIG_WORD_W-1] : 1'b0;
      end else if (txs_fall) begin
        tx_data_oe  <= 1'b0;                            // [R17]
      end else if (txs_m[1] && txc_rise) begin
        tx_shift    <= {tx_shift[`PCMSIG_WORD_W-2:0], 1'b0}; // [R21]
        tx_data_out <= tx_shift[`PCMSIG_WORD_W-2];      // [R17]
      end
    end
  end
endmodule // pcmsig_codec
`default_nettype wire

// file: src/pcmsig_map.vh
`ifndef PCMSIG_MAP_VH
`define PCMSIG_MAP_VH
// word layout, transferred sign first
`define PCMSIG_WORD_W      8
`define PCMSIG_SIGN_BIT    7
`define PCMSIG_CHORD_HI    6
`define PCMSIG_CHORD_LO    4
`define PCMSIG_STEP_HI     3
`define PCMSIG_STEP_LO     0
`define PCMSIG_SIG_BIT     0
`define PCMSIG_CNT_W       4
`define PCMSIG_BITS        4'h8
`define PCMSIG_CNT_ZERO    4'h0
`define PCMSIG_CNT_ONE     4'h1
// linear decoded magnitude in half-step units of the first chord
`define PCMSIG_LIN_W       14
`define PCMSIG_LIN_ZERO    14'h0000
`define PCMSIG_BIAS        14'h0021
`define PCMSIG_HALF_STEP   14'h0001
`define PCMSIG_ZERO_CODE   8'h00
// conversion sequencing on ref_clk (40 MHz, 25 ns)
`define PCMSIG_CLK_NS      25
`define PCMSIG_DAC_DLY_NS  7000
`define PCMSIG_OFS_CYC     8'h04
`define PCMSIG_TMR_W       8
`define PCMSIG_TMR_ZERO    8'h00
`define PCMSIG_TMR_ONE     8'h01
// fifo between encoder result and transmit shifter
`define PCMSIG_FIFO_DEPTH  8
`define PCMSIG_FIFO_AW     3
`endif

// file: src/pcmsig_fifo.v
`timescale 1ns/1ps
`default_nettype none
module pcmsig_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    out_data = mem[rd_ptr];
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // pcmsig_fifo
`default_nettype wire

// file: testbench/pcmsig_codec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcmsig_map.vh"
// ==============================================================
// port checker for the codec
module pcmsig_codec_chk (
  input wire logic                      ref_clk,
  input wire logic                      resetn,
  input wire logic                      tx_frame_sync,
  input wire logic                      rx_frame_sync,
  input wire logic                      tx_data_oe,
  input wire logic                      signal_out_a,
  input wire logic                      signal_out_b,
  input wire logic                      enc_start,
  input wire logic                      enc_offset_null,
  input wire logic [`PCMSIG_WORD_W-1:0] dac_word,
  input wire logic                      dac_sign,
  input wire logic                      dac_update
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  oe_rise_a: assert property (
    $rose(tx_frame_sync) |-> ##[2:4] tx_data_oe) else $error("no drive");
  oe_fall_a: assert property (
    $fell(tx_frame_sync) |-> ##[2:4] !tx_data_oe) else $error("no float");
  oe_idle_a: assert property (
    !tx_frame_sync [*5] |-> !tx_data_oe) else $error("driven idle");
  null_len_a: assert property (
    $rose(enc_offset_null) |-> enc_offset_null [*4] ##1 !enc_offset_null)
    else $error("null length");
  null_first_a: assert property (
    enc_start |-> $past(enc_offset_null)) else $error("start no null");
  dac_time_a: assert property (
    $fell(rx_frame_sync) |-> ##[280:290] dac_update) else $error("dac late");
  sign_match_a: assert property (
    dac_update |-> dac_sign == dac_word[7]) else $error("sign");
  sig_hold_a: assert property (
    rx_frame_sync |=> $stable(signal_out_a) && $stable(signal_out_b)
      && !dac_update) else $error("output in frame");
endmodule // pcmsig_codec_chk
bind pcmsig_codec pcmsig_codec_chk u_pcmsig_codec_chk (
  .ref_clk(ref_clk), .resetn(resetn), .tx_frame_sync(tx_frame_sync),
  .rx_frame_sync(rx_frame_sync), .tx_data_oe(tx_data_oe),
  .signal_out_a(signal_out_a), .signal_out_b(signal_out_b),
  .enc_start(enc_start), .enc_offset_null(enc_offset_null),
  .dac_word(dac_word), .dac_sign(dac_sign), .dac_update(dac_update));
`default_nettype wire

// file: testbench/pcmsig_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// channel bank: both links, bit clock 200 ns, idle low between frames
module pcmsig_bank_model (
  input  wire logic ref_clk,
  input  wire logic tx_data_out,
  input  wire logic tx_data_oe,
  output var  logic tx_frame_sync,
  output var  logic tx_bit_clock,
  output var  logic rx_frame_sync,
  output var  logic rx_bit_clock,
  output var  logic rx_data
);
  initial begin
    tx_frame_sync = 1'b0;
    tx_bit_clock = 1'b0;
    rx_frame_sync = 1'b0;
    rx_bit_clock = 1'b0;
    rx_data = 1'b1;
  end
  // eight bits each way, sign first
  task automatic frame(input logic [7:0] w, output logic [7:0] got);
    int i;
    tx_frame_sync <= 1'b1;
    rx_frame_sync <= 1'b1;
    rx_data <= w[7];
    for (i = 7; i >= 0; i--) begin
      repeat (4) @(posedge ref_clk);
      got[i] = tx_data_oe ? tx_data_out : 1'bx;
      tx_bit_clock <= 1'b1;
      rx_bit_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      tx_bit_clock <= 1'b0;
      rx_bit_clock <= 1'b0;
      if (i > 0) rx_data <= w[i-1];
    end
    repeat (4) @(posedge ref_clk);
    tx_frame_sync <= 1'b0;
    rx_frame_sync <= 1'b0;
    rx_data <= ~w[0];
    // gap fills out the 125 us frame period, far beyond 17 master clocks
    repeat (4932) @(posedge ref_clk);
  endtask
endmodule // pcmsig_bank_model
`default_nettype wire

// file: testbench/pcmsig_codec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcmsig_codec_tb;
  logic        ref_clk, resetn, tx_signal_select, rx_signal_route;
  logic        signal_in_a, signal_in_b, enc_done;
  logic [7:0]  enc_code, got;
  logic [2:0]  enc_wait;
  wire         tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock;
  wire         rx_data, tx_data_out, tx_data_oe, signal_out_a, signal_out_b;
  wire         enc_start, enc_offset_null, dac_sign, dac_update;
  wire [7:0]   dac_word;
  wire [13:0]  dac_level;
  int          mismatches, checks_done, cycles;
  pcmsig_codec u_pcmsig_codec (.ref_clk(ref_clk), .resetn(resetn),
    .tx_frame_sync(tx_frame_sync), .tx_bit_clock(tx_bit_clock),
    .rx_frame_sync(rx_frame_sync), .rx_bit_clock(rx_bit_clock),
    .rx_data(rx_data), .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe),
    .tx_signal_select(tx_signal_select), .rx_signal_route(rx_signal_route),
    .signal_in_a(signal_in_a), .signal_in_b(signal_in_b),
    .signal_out_a(signal_out_a), .signal_out_b(signal_out_b),
    .enc_code(enc_code), .enc_done(enc_done), .enc_start(enc_start),
    .enc_offset_null(enc_offset_null), .dac_word(dac_word),
    .dac_level(dac_level), .dac_sign(dac_sign), .dac_update(dac_update));
  pcmsig_bank_model u_pcmsig_bank_model (.ref_clk(ref_clk),
    .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe),
    .tx_frame_sync(tx_frame_sync), .tx_bit_clock(tx_bit_clock),
    .rx_frame_sync(rx_frame_sync), .rx_bit_clock(rx_bit_clock),
    .rx_data(rx_data));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==============================================================
  // converter stand-in: new code six cycles after each start
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    enc_done <= (enc_wait == 3'h1);
    if (enc_wait == 3'h1) enc_code <= enc_code + 8'h37;
    if (enc_start) enc_wait <= 3'h6;
    else if (enc_wait != 3'h0) enc_wait <= enc_wait - 3'h1;
    if (cycles == 30000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // sent word carries the previous code with the chosen signal in its LSB
  task automatic run_frame(input logic [7:0] w, input logic tx_chk,
                           input logic sig);
    logic [7:0] want_tx;
    want_tx = {enc_code[7:1], sig};
    u_pcmsig_bank_model.frame(w, got);
    if (tx_chk) check(got, want_tx);
    check(dac_word, w);
  endtask
  task automatic t_route_a;
    tx_signal_select <= 1'b1;
    rx_signal_route <= 1'b1;
    signal_in_a <= 1'b1;
    signal_in_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    run_frame(8'h3C, 1'b1, 1'b0);
    check(signal_out_a, 1'b0);
    check(dac_level, 14'h024F);
    run_frame(8'hA5, 1'b1, 1'b1);
    check(signal_out_a, 1'b1);
    check(dac_level, 14'h067F);
  endtask
  task automatic t_route_b;
    tx_signal_select <= 1'b0;
    rx_signal_route <= 1'b0;
    signal_in_a <= 1'b0;
    signal_in_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    run_frame(8'h81, 1'b1, 1'b1);
    check({signal_out_a, signal_out_b}, 2'h3);
    check(dac_level, 14'h1EDF);
    run_frame(8'h7E, 1'b1, 1'b1);
    check({signal_out_a, signal_out_b}, 2'h2);
    check(dac_level, 14'h0001);
  endtask
  initial begin
    resetn = 1'b0;
    tx_signal_select = 1'b0;
    rx_signal_route = 1'b0;
    signal_in_a = 1'b0;
    signal_in_b = 1'b0;
    enc_done = 1'b0;
    enc_code = 8'h5A;
    enc_wait = 3'h0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // first sent word only primes the pipeline
    run_frame(8'h01, 1'b0, 1'b0);
    t_route_a;
    t_route_b;
    end_of_test;
  end
endmodule // pcmsig_codec_tb
`default_nettype wire
